// File: hw/rtc_oscillator_control_status_regs.sv
// Function
// RQ1 - 010 runs oscillator and divider
// RQ2 - 011 runs too, event register writable
// RQ3 - test bit drives raw time base out
// RQ4 - 11X runs oscillator, divider held
// RQ5 - other patterns keep oscillator stopped
// RQ6 - power fail blocks clock/storage writes
// RQ7 - protection persists for recovery interval
// RQ8 - control registers accessible any time
// RQ9 - first register writable except bit 7
// RQ10 - first register: rate, run, update status
// RQ11 - second register fully read/write; here bit 4 reads 0 while bit 7 is set
// RQ12 - event register: flags and raw enable
// RQ13 - integrity register read-only, bit7 valid
// RQ14 - reset clears listed bits only
// RQ15 - first update 500ms after 010
// RQ16 - event register read clears flags
// RQ17 - power fail input, ticks time recovery
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_ctrl_defs.svh"

module rtc_oscillator_control_status_regs #(
	parameter int unsigned HOLD_TICKS = `WP_HOLD_TICKS
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins from outside.
	input wire logic power_fail,
	input wire logic backup_valid,
	input wire logic alarm_match,
	// Pins to outside.
	output logic square_wave_pin,
	output logic irq_pin_out,
	output logic irq_pin_oe,
	output logic write_block,
	output logic oscillator_on,
	output logic irq
);
	import rtc_ctrl_pkg::*;

	function automatic osc_mode_t decode_run(input logic [2:0] sel);
		if (sel == `RUN_NORMAL)
			return OSC_RUN;
		else if (sel == `RUN_TEST)
			return OSC_RUN_TEST;
		else if (sel[2:1] == 2'b11)
			return OSC_HOLD;
		else
			return OSC_OFF;
	endfunction

	// Divider tap for a rate; 0 means no output.
	function automatic logic [3:0] tap_of(input logic [3:0] rs);
		if (rs == 4'h0)
			return 4'h0;
		else if (rs < 4'h3)
			return rs + 4'h7;
		else
			return rs - 4'h1;
	endfunction

	// Synchronisers for the pins.
	logic pf_s1_q, pf_s2_q, bv_s1_q, bv_s2_q;
	logic al_s1_q, al_s2_q, al_s3_q;

	always_ff @(posedge aclk) begin
		pf_s1_q <= power_fail;
		pf_s2_q <= pf_s1_q;
		bv_s1_q <= backup_valid;
		bv_s2_q <= bv_s1_q;
		al_s1_q <= alarm_match;
		al_s2_q <= al_s1_q;
		al_s3_q <= al_s2_q;
	end

	logic alarm_ev;
	assign alarm_ev = al_s2_q & ~al_s3_q;

	// Control register fields.
	logic [2:0] run_sel_q;
	logic [3:0] rate_select_q;
	logic transfer_inhibit_q, periodic_irq_enable_q, alarm_irq_enable_q;
	logic update_irq_enable_q, square_wave_enable_q;
	logic number_format_select_q, hour_mode_select_q;
	logic daylight_adjust_enable_q;
	logic irq_request_flag_q, periodic_event_flag_q;
	logic alarm_event_flag_q, update_done_flag_q, raw_clock_out_enable_q;
	logic update_in_progress_q;

	osc_mode_t mode;
	logic osc_run, div_run, c_writable;
	assign mode = decode_run(run_sel_q);
	assign osc_run = (mode != OSC_OFF); // see RQ5
	assign div_run = (mode == OSC_RUN) || (mode == OSC_RUN_TEST); // see RQ4
	assign c_writable = (mode == OSC_RUN_TEST); // see RQ2

	// Time base: half periods of the 32.768kHz oscillator.
	localparam int unsigned HALF_CYC = `HALF_PERIOD_CYCLES;
	logic [10:0] half_cnt_q;
	logic raw_clk_q;
	logic half_ev, tick;
	assign half_ev = osc_run && (half_cnt_q == 11'(HALF_CYC - 1));
	assign tick = half_ev && !raw_clk_q;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			half_cnt_q <= 11'h000;
		else if (!osc_run || half_ev)
			half_cnt_q <= 11'h000;
		else
			half_cnt_q <= half_cnt_q + 11'h001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			raw_clk_q <= 1'b0;
		else if (!osc_run)
			raw_clk_q <= 1'b0;
		else if (half_ev)
			raw_clk_q <= ~raw_clk_q;
	end

	// Bus handshake state.
	logic aw_have_q, w_have_q, ar_have_q;
	logic [5:0] aw_idx_q, ar_idx_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic wr_fire, rd_fire, wr_en;
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign rd_fire = ar_have_q && !s_axi_rvalid;
	assign wr_en = wr_fire && wlane_q; // see RQ8

	logic wr_a, wr_b, wr_c, wr_st, wr_mk, rd_c;
	assign wr_a = wr_en && (aw_idx_q == `IDX_RATE_OSC);
	assign wr_b = wr_en && (aw_idx_q == `IDX_MODE_EN);
	assign wr_c = wr_en && (aw_idx_q == `IDX_EVENT_FLAGS) && c_writable;
	assign wr_st = wr_en && (aw_idx_q == `IDX_IRQ_STATUS);
	assign wr_mk = wr_en && (aw_idx_q == `IDX_IRQ_MASK);
	assign rd_c = rd_fire && (ar_idx_q == `IDX_EVENT_FLAGS);

	// Divider chain and update cycle.
	logic [14:0] div_q;
	logic update_ev;
	assign update_ev = tick && div_run && (div_q == 15'h7fff);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_q <= 15'h0000;
		else if (wr_a && s_axi_wdata[6:4] == `RUN_NORMAL)
			div_q <= 15'(32768 - `FIRST_UPDATE_TICKS); // see RQ15
		else if (tick && div_run)
			div_q <= div_q + 15'h0001; // see RQ1
	end

	always_ff @(posedge aclk) begin
		if (transfer_inhibit_q || !div_run)
			update_in_progress_q <= 1'b0;
		else
			update_in_progress_q <=
				(div_q >= 15'(32768 - `UPDATE_WINDOW_TICKS)); // see RQ10
	end

	// Periodic event from the selected divider tap.
	logic [3:0] tap;
	logic [14:0] low_mask;
	logic periodic_ev, tap_level;
	assign tap = tap_of(rate_select_q);
	assign low_mask = 15'((16'h0001 << tap) - 16'h0001);
	assign periodic_ev = tick && div_run && (tap != 4'h0)
		&& ((div_q & low_mask) == low_mask);
	assign tap_level = (tap != 4'h0) && div_q[tap - 4'h1];

	// First control register: reset clears only the two low run bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_sel_q[1:0] <= 2'b00; // see RQ14
		end else if (wr_a) begin
			run_sel_q <= wbyte_q[6:4]; // see RQ9
			rate_select_q <= wbyte_q[3:0];
		end
	end

	// Second control register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periodic_irq_enable_q <= 1'b0; // see RQ14
			alarm_irq_enable_q <= 1'b0;
			update_irq_enable_q <= 1'b0;
			square_wave_enable_q <= 1'b0;
		end else if (wr_b) begin
			periodic_irq_enable_q <= wbyte_q[`BIT_PERIODIC_IRQ_EN]; // see RQ11
			alarm_irq_enable_q <= wbyte_q[`BIT_ALARM_IRQ_EN];
			update_irq_enable_q <= wbyte_q[`BIT_UPDATE_IRQ_EN]
				& ~wbyte_q[`BIT_TRANSFER_INHIBIT];
			square_wave_enable_q <= wbyte_q[`BIT_SQUARE_WAVE_EN];
		end else if (transfer_inhibit_q) begin
			update_irq_enable_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (wr_b) begin
			transfer_inhibit_q <= wbyte_q[`BIT_TRANSFER_INHIBIT];
			number_format_select_q <= wbyte_q[2];
			hour_mode_select_q <= wbyte_q[1];
			daylight_adjust_enable_q <= wbyte_q[0];
		end
	end

	// Event register. A new event wins over the clear by read.
	logic pf_d, af_d, uf_d, req_d;
	always_comb begin
		pf_d = periodic_event_flag_q;
		af_d = alarm_event_flag_q;
		uf_d = update_done_flag_q;
		req_d = irq_request_flag_q;
		if (rd_c) begin
			pf_d = 1'b0; // see RQ16
			af_d = 1'b0;
			uf_d = 1'b0;
			req_d = 1'b0;
		end
		if (wr_c) begin
			pf_d = wbyte_q[`BIT_PERIODIC_FLAG]; // see RQ2
			af_d = wbyte_q[`BIT_ALARM_FLAG];
			uf_d = wbyte_q[`BIT_UPDATE_FLAG];
			req_d = wbyte_q[`BIT_IRQ_REQUEST];
		end
		pf_d = pf_d | periodic_ev;
		af_d = af_d | alarm_ev;
		uf_d = uf_d | update_ev;
		req_d = req_d
			| (periodic_ev & periodic_irq_enable_q)
			| (alarm_ev & alarm_irq_enable_q)
			| (update_ev & update_irq_enable_q & ~transfer_inhibit_q);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periodic_event_flag_q <= 1'b0; // see RQ14
			alarm_event_flag_q <= 1'b0;
			update_done_flag_q <= 1'b0;
			irq_request_flag_q <= 1'b0;
			raw_clock_out_enable_q <= 1'b0;
		end else begin
			periodic_event_flag_q <= pf_d; // see RQ12
			alarm_event_flag_q <= af_d;
			update_done_flag_q <= uf_d;
			irq_request_flag_q <= req_d;
			if (wr_c)
				raw_clock_out_enable_q <= wbyte_q[`BIT_RAW_CLOCK_OUT];
			else if (rd_c)
				raw_clock_out_enable_q <= 1'b0;
		end
	end

	// Power fail protection and its recovery interval.
	logic [31:0] hold_q;
	logic protect, recovered_ev;
	assign protect = pf_s2_q || (hold_q != 32'h0);
	assign recovered_ev = !pf_s2_q && (hold_q == 32'h1) && tick;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			hold_q <= 32'h0;
		else if (pf_s2_q)
			hold_q <= HOLD_TICKS; // see RQ17
		else if (tick && hold_q != 32'h0)
			hold_q <= hold_q - 32'h1; // see RQ7
	end

	// Interrupt status, mask and output.
	logic [`IRQ_WIDTH-1:0] irq_st_q, irq_mask_q, irq_set;
	assign irq_set = {recovered_ev, update_ev, alarm_ev, periodic_ev};

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_st_q <= `RST_IRQ;
		else if (wr_st)
			irq_st_q <= (irq_st_q & ~wbyte_q[`IRQ_WIDTH-1:0]) | irq_set;
		else
			irq_st_q <= irq_st_q | irq_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_mask_q <= `RST_IRQ;
		else if (wr_mk)
			irq_mask_q <= wbyte_q[`IRQ_WIDTH-1:0];
	end

	// Pin outputs, all registered.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			square_wave_pin <= 1'b0;
			irq_pin_out <= 1'b0;
			irq_pin_oe <= 1'b0;
			write_block <= 1'b1;
			oscillator_on <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (c_writable && raw_clock_out_enable_q)
				square_wave_pin <= raw_clk_q; // see RQ3
			else
				square_wave_pin <= square_wave_enable_q && div_run
					&& tap_level;
			irq_pin_out <= 1'b0;
			irq_pin_oe <= req_d; // see RQ16
			write_block <= protect; // see RQ6
			oscillator_on <= osc_run; // see RQ1
			irq <= |(irq_st_q & irq_mask_q);
		end
	end

	// Write channel: address and data taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_idx_q <= 6'h00;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr[7:2];
				s_axi_awready <= 1'b0;
			end else if (!aw_have_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wbyte_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end else if (!w_have_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_idx_q >= `IDX_RATE_OSC
					&& aw_idx_q <= `IDX_IRQ_MASK)
					? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel.
	logic [7:0] rbyte;
	logic rhit;
	always_comb begin
		rbyte = 8'h00;
		rhit = 1'b1;
		case (ar_idx_q)
			`IDX_RATE_OSC: rbyte = {update_in_progress_q, run_sel_q,
				rate_select_q};
			`IDX_MODE_EN: rbyte = {transfer_inhibit_q,
				periodic_irq_enable_q, alarm_irq_enable_q,
				update_irq_enable_q, square_wave_enable_q,
				number_format_select_q, hour_mode_select_q,
				daylight_adjust_enable_q};
			`IDX_EVENT_FLAGS: rbyte = {irq_request_flag_q,
				periodic_event_flag_q, alarm_event_flag_q,
				update_done_flag_q, 1'b0, raw_clock_out_enable_q,
				2'b00};
			`IDX_BACKUP_STAT: rbyte = {bv_s2_q, 7'h00}; // see RQ13
			`IDX_IRQ_STATUS: rbyte = {4'h0, irq_st_q};
			`IDX_IRQ_MASK: rbyte = {4'h0, irq_mask_q};
			default: rhit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_have_q <= 1'b0;
			ar_idx_q <= 6'h00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				ar_have_q <= 1'b1;
				ar_idx_q <= s_axi_araddr[7:2];
				s_axi_arready <= 1'b0;
			end else if (!ar_have_q && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
			if (rd_fire) begin
				ar_have_q <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rbyte};
				s_axi_rresp <= rhit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // rtc_oscillator_control_status_regs

`default_nettype wire

// File: hw/rtc_ctrl_defs.svh
`ifndef RTC_CTRL_DEFS_SVH
`define RTC_CTRL_DEFS_SVH

// Register indices; the byte address is four times the index.
`define IDX_RATE_OSC 6'h0a
`define IDX_MODE_EN 6'h0b
`define IDX_EVENT_FLAGS 6'h0c
`define IDX_BACKUP_STAT 6'h0d
`define IDX_IRQ_STATUS 6'h0e
`define IDX_IRQ_MASK 6'h0f

// Field positions in the first and second control registers.
`define BIT_UPDATE_IN_PROGRESS 7
`define POS_RUN_SELECT 4
`define BIT_TRANSFER_INHIBIT 7
`define BIT_PERIODIC_IRQ_EN 6
`define BIT_ALARM_IRQ_EN 5
`define BIT_UPDATE_IRQ_EN 4
`define BIT_SQUARE_WAVE_EN 3

// Field positions in the event and integrity registers.
`define BIT_IRQ_REQUEST 7
`define BIT_PERIODIC_FLAG 6
`define BIT_ALARM_FLAG 5
`define BIT_UPDATE_FLAG 4
`define BIT_RAW_CLOCK_OUT 2
`define BIT_BACKUP_VALID 7

// Interrupt status and mask layout.
`define IRQ_PERIODIC 0
`define IRQ_ALARM 1
`define IRQ_UPDATE 2
`define IRQ_RECOVERED 3
`define IRQ_WIDTH 4

// Reset values.
`define RST_EVENT_FLAGS 8'h00
`define RST_IRQ 4'h0

// Run select patterns.
`define RUN_NORMAL 3'b010
`define RUN_TEST 3'b011

// Timing.
`define CLK_HZ 50000000
`define TIMEBASE_HZ 32768
`define HALF_PERIOD_CYCLES (`CLK_HZ / (2 * `TIMEBASE_HZ))
`define FIRST_UPDATE_MS 500
`define FIRST_UPDATE_TICKS ((`FIRST_UPDATE_MS * `TIMEBASE_HZ) / 1000)
`define UPDATE_WINDOW_TICKS 8
`define WP_HOLD_MS 200
`define WP_HOLD_TICKS ((`WP_HOLD_MS * `TIMEBASE_HZ + 999) / 1000)

// Bus responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: hw/rtc_ctrl_pkg.sv
`default_nettype none
package rtc_ctrl_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {
		OSC_OFF = 2'b00,
		OSC_RUN = 2'b01,
		OSC_RUN_TEST = 2'b10,
		OSC_HOLD = 2'b11
	} osc_mode_t;

endpackage

`default_nettype wire

// File: tb/rtc_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_regs_props #(
	parameter int unsigned HOLD_TICKS = 4
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins.
	input wire logic power_fail,
	input wire logic backup_valid,
	input wire logic alarm_match,
	input wire logic square_wave_pin,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe,
	input wire logic write_block,
	input wire logic oscillator_on,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_at(a);
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
			s_axi_wstrb[0] && s_axi_awaddr == a;
	endsequence
	sequence rd_at(a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence
	chk_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid) else $error("write not answered");
	chk_bresp_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_integrity_zero: assert property (
		rd_at(8'h34) |-> ##2 s_axi_rvalid && s_axi_rdata[31:8] == 24'h0 &&
			s_axi_rdata[6:0] == 7'h00) else $error("integrity bits not zero");
	chk_run_starts: assert property (
		wr_at(8'h28) ##0 (s_axi_wdata[6:5] == 2'h1 || s_axi_wdata[6:5] == 2'h3)
			|-> ##[1:3] oscillator_on) else $error("oscillator not started");
	chk_run_stops: assert property (
		wr_at(8'h28) ##0 (s_axi_wdata[6:5] == 2'h0 || s_axi_wdata[6:5] == 2'h2)
			|-> ##[1:3] !oscillator_on) else $error("oscillator not stopped");
	chk_read_release: assert property (
		rd_at(8'h30) |-> ##[1:3] !irq_pin_oe) else $error("irq pin not released");
	chk_fail_blocks: assert property (
		power_fail [*5] |-> write_block) else $error("writes not blocked");
	chk_hold_after: assert property (
		$fell(power_fail) && write_block |=> write_block [*8])
		else $error("protection released early");
endmodule // rtc_regs_props
bind rtc_oscillator_control_status_regs rtc_regs_props #(
	.HOLD_TICKS(HOLD_TICKS)
) rtc_regs_props_i (.*);
`default_nettype wire

// File: tb/rtc_oscillator_control_status_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_oscillator_control_status_regs_tb_top;
	import rtc_ctrl_pkg::*;
	localparam int unsigned HOLD = 4;
	localparam int TICK = 1524;
	typedef struct {
		logic [7:0] a;
		logic [31:0] d;
		byte_t e;
		logic [1:0] r;
	} row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic power_fail = 1'b0;
	logic backup_valid = 1'b1;
	logic alarm_match = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, square_wave_pin, irq_pin_out, irq_pin_oe;
	logic write_block, oscillator_on, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata;
	byte_t rdv;
	int err_total = 0;
	int total_checks = 0;
	int hi = 0;
	int lo = 0;
	int n = 0;
	row_t rows [6] = '{'{8'h28, 32'haa, 8'h2a, 2'h0},
		'{8'h2c, 32'hff, 8'hef, 2'h0}, '{8'h2c, 32'h06, 8'h06, 2'h0},
		'{8'h30, 32'hff, 8'h00, 2'h0}, '{8'h34, 32'h00, 8'h80, 2'h0},
		'{8'h40, 32'h5a, 8'h00, 2'h2}};

	always #10 aclk = ~aclk;

	rtc_oscillator_control_status_regs #(
		.HOLD_TICKS(HOLD)
	) rtc_oscillator_control_status_regs_i (.*);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// Address and data are offered together and each is held until taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && k < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (k >= 100) chk(0, 1, "write hung");
	endtask

	task automatic rd_reg(input logic [7:0] a, output byte_t d,
		output logic [1:0] r);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && k < 100);
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (k >= 100) chk(0, 1, "read hung");
	endtask

	task automatic rchk(input logic [7:0] a, input byte_t e, input string m);
		rd_reg(a, rdv, rs);
		chk(rdv, e, m);
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(3);
		chk(oscillator_on, 0, "osc after reset");
		rchk(8'h30, 8'h00, "events after reset");
		rd_reg(8'h2c, rdv, rs);
		chk(rdv & 8'h78, 0, "enables after reset");
		rd_reg(8'h28, rdv, rs);
		chk(rdv & 8'h30, 0, "run bits after reset");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rs);
			rd_reg(rows[i].a, rdv, rs);
			chk(rdv, rows[i].e, "row data");
			chk(rs, rows[i].r, "row resp");
		end
		wr(8'h40, 32'h1, rs);
		chk(rs, 2'h2, "unmapped write");
		for (int p = 0; p < 8; p++) begin
			wr(8'h28, {p[2:0], 4'ha}, rs);
			cyc(3);
			chk(oscillator_on, p == 2 || p == 3 || p >= 6, "run");
		end
		wr(8'h28, 32'h3a, rs);
		wr(8'h30, 32'h04, rs);
		repeat (2000) begin
			@(posedge aclk);
			hi += square_wave_pin;
			lo += !square_wave_pin;
		end
		chk(hi > 400 && lo > 400, 1, "raw clock out");
		rchk(8'h30, 8'h04, "test mode write");
		rchk(8'h30, 8'h00, "read clears");
		wr(8'h28, 32'h2a, rs);
		wr(8'h3c, 32'h0, rs);
		wr(8'h2c, 32'h22, rs);
		alarm_match <= 1'b1;
		cyc(6);
		alarm_match <= 1'b0;
		cyc(6);
		chk(irq, 0, "masked irq");
		chk(irq_pin_oe, 1, "request pin");
		chk(irq_pin_out, 0, "pin drives low");
		rchk(8'h38, 8'h02, "irq status");
		wr(8'h3c, 32'h02, rs);
		cyc(3);
		chk(irq, 1, "unmasked irq");
		rchk(8'h30, 8'ha0, "alarm flags");
		cyc(2);
		chk(irq_pin_oe, 0, "pin released");
		wr(8'h38, 32'h02, rs);
		cyc(3);
		chk(irq, 0, "irq cleared");
		power_fail <= 1'b1;
		cyc(8);
		chk(write_block, 1, "fail blocks");
		wr(8'h2c, 32'h02, rs);
		rchk(8'h2c, 8'h02, "control during fail");
		power_fail <= 1'b0;
		cyc(10);
		chk(write_block, 1, "hold");
		while (write_block === 1'b1 && n < 9000) begin
			@(posedge aclk);
			n++;
		end
		chk(n > (HOLD - 1) * TICK - 20 && n < (HOLD + 1) * TICK, 1, "hold");
		rchk(8'h38, 8'h08, "recovery event");
		wr(8'h28, 32'h6a, rs);
		wr(8'h2c, 32'h6f, rs);
		aresetn <= 1'b0;
		cyc(4);
		aresetn <= 1'b1;
		cyc(3);
		rchk(8'h28, 8'h4a, "kept run bit");
		rchk(8'h2c, 8'h07, "kept formats");
		wrap_up;
	end

	initial begin
		#2000000;
		err_total++;
		wrap_up;
	end
endmodule // rtc_oscillator_control_status_regs_tb_top
`default_nettype wire
